//--- design/tmr_pkg.sv
`default_nettype none
package tmr_pkg;
    // ==========================================
    // register offsets
    localparam logic [2:0] TMR_OFF_CONTROL_A = 3'h0;
    localparam logic [2:0] TMR_OFF_COUNT = 3'h1;
    localparam logic [2:0] TMR_OFF_COMPARE = 3'h2;
    localparam logic [2:0] TMR_OFF_MASK = 3'h3;
    localparam logic [2:0] TMR_OFF_FLAGS = 3'h4;
    // ==========================================
    // field positions
    localparam int TMR_BIT_FORCE = 7;
    localparam int TMR_BIT_WGM_HI = 6;
    localparam int TMR_BIT_WGM_LO = 3;
    localparam int TMR_BIT_COM_HI = 5;
    localparam int TMR_BIT_COM_LO = 4;
    localparam int TMR_BIT_CMP = 1;
    localparam int TMR_BIT_OVF = 0;
    localparam logic [7:0] TMR_CTRL_MASK = 8'h7f;
    localparam logic [7:0] TMR_IRQ_MASK = 8'h03;
    // ==========================================
    // values
    localparam logic [7:0] TMR_MAX = 8'hff;
    localparam logic [7:0] TMR_BOTTOM = 8'h00;
    localparam logic [7:0] TMR_RESET_BYTE = 8'h00;
    localparam logic [9:0] TMR_DIV8 = 10'h007;
    localparam logic [9:0] TMR_DIV64 = 10'h03f;
    localparam logic [9:0] TMR_DIV256 = 10'h0ff;
    localparam logic [9:0] TMR_DIV1024 = 10'h3ff;
    typedef enum logic [1:0] {TMR_NORMAL, TMR_PWM_PC, TMR_CTC, TMR_PWM_FAST} tmr_mode_t;
    typedef enum logic [1:0] {TMR_COM_OFF, TMR_COM_TOGGLE, TMR_COM_CLEAR, TMR_COM_SET} tmr_com_t;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmr_bus_t;
endpackage
`default_nettype wire

//--- design/tmr_timer8.sv
// Decided for this implementation: the placing of the registers and strobed register access.
`default_nettype none
// Contract
// - writing force bit forces immediate compare event on output per output mode
// - force strobe acts only in normal and clear-on-compare modes
// - forced compare sets no flag and never clears counter
// - force bit always reads zero
// - mode field bits 6,3: normal, phase-correct, clear-on-compare, fast
// - TOP 0xff except compare value in clear-on-compare; overflow point per mode
// - compare writes immediate in non-PWM, buffered until TOP in PWM
// - nonzero output mode overrides port; software sets direction bit; here value 01 in the PWM modes does not override
// - non-PWM output modes: off, toggle, clear, set on match
// - fast PWM: off, reserved, clear-match/set-TOP, set-match/clear-TOP
// - phase-correct: off, reserved, clear up-match/set down-match, or inverse
// - PWM with compare equal TOP and high bit: match ignored, TOP action kept
// - clock select: stop, /1, /8, /64, /256, /1024, pin fall, pin rise
// - pin edges count even when pin is an output
// - counter is read and written by software
// - counter write blocks compare match on next timer tick
// - compare register compared continuously, equality sets compare flag
// - compare interrupt when enable, global bit and flag all one
// - overflow interrupt when enable, global bit and flag all one
// - compare flag cleared by vector acknowledge or writing one
// - overflow flag cleared by vector acknowledge or writing one
// - phase-correct sets overflow at direction change at zero
// - normal and clear-on-compare set overflow on wrap from MAX
// - fast PWM counts to MAX then clears next tick
module tmr_timer8
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire tmr_bus_t bus,
    output logic [7:0] rdata,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    output logic compare_irq,
    output logic overflow_irq,
    input wire logic external_count_pin,
    output logic compare_output_pin,
    output logic compare_output_override
);
    // ==========================================
    // registers
    logic [7:0] ctrl_r;
    logic [7:0] count_r;
    logic [7:0] cmp_r;
    logic [7:0] cmp_buf_r;
    logic [1:0] mask_r;
    logic cmp_flag_r;
    logic ovf_flag_r;
    logic [9:0] presc_r;
    logic ext_d_r;
    logic down_r;
    logic block_r;
    logic oc_r;

    tmr_mode_t mode;
    tmr_com_t com;
    logic [2:0] clock_select_field;
    logic pwm;
    logic tick;
    logic [7:0] top;
    logic match;
    logic at_top;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp;
    logic force_compare_strobe;
    logic cmp_set;
    logic ovf_set;
    logic [7:0] count_nxt;
    logic [1:0] force_com;
    logic force_pwm;
    logic fast_top_hit;
    logic pc_top_hit;
    logic wr_flags;
    logic wr_mask;
    logic clr_cmp;
    logic clr_ovf;
    logic [7:0] rdata_nxt;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] off, input logic st);
        return st && (a == off);
    endfunction

    assign mode = tmr_mode_t'({ctrl_r[TMR_BIT_WGM_HI], ctrl_r[TMR_BIT_WGM_LO]});
    assign com = tmr_com_t'({ctrl_r[TMR_BIT_COM_HI], ctrl_r[TMR_BIT_COM_LO]});
    assign clock_select_field = ctrl_r[2:0];
    assign pwm = (mode == TMR_PWM_PC) || (mode == TMR_PWM_FAST);
    assign wr_ctrl = hit(bus.addr, TMR_OFF_CONTROL_A, bus.wr);
    assign wr_count = hit(bus.addr, TMR_OFF_COUNT, bus.wr);
    assign wr_cmp = hit(bus.addr, TMR_OFF_COMPARE, bus.wr);
    // the strobe acts on the fields written beside it, not on the old ones
    assign force_com = bus.wdata[TMR_BIT_COM_HI:TMR_BIT_COM_LO];
    // low mode bit set means one of the two PWM modes
    assign force_pwm = bus.wdata[TMR_BIT_WGM_LO];
    // force ignored in PWM modes; software keeps it zero there anyway
    assign force_compare_strobe = wr_ctrl && bus.wdata[TMR_BIT_FORCE] && !force_pwm;

    // ==========================================
    // clock select
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            presc_r <= 10'h000;
        else
            presc_r <= presc_r + 10'h001;
    end

    // pin sampled regardless of its direction
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ext_d_r <= 1'b0;
        else
            ext_d_r <= external_count_pin;
    end

    always_comb
    begin
        unique case (clock_select_field)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = (presc_r[2:0] == TMR_DIV8[2:0]);
            3'h3: tick = (presc_r[5:0] == TMR_DIV64[5:0]);
            3'h4: tick = (presc_r[7:0] == TMR_DIV256[7:0]);
            3'h5: tick = (presc_r == TMR_DIV1024);
            3'h6: tick = ext_d_r && !external_count_pin;
            3'h7: tick = !ext_d_r && external_count_pin;
        endcase
    end

    assign top = (mode == TMR_CTC) ? cmp_r : TMR_MAX;
    assign at_top = (count_r == top);
    // compare equal TOP with high bit set in PWM: no match action
    assign match = tick && !block_r && (count_r == cmp_r)
                   && !(pwm && com[1] && (cmp_r == TMR_MAX));

    // ==========================================
    // control and compare registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_r <= TMR_RESET_BYTE;
        else if (wr_ctrl)
            ctrl_r <= bus.wdata & TMR_CTRL_MASK;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cmp_buf_r <= TMR_RESET_BYTE;
        else if (wr_cmp)
            cmp_buf_r <= bus.wdata;
    end

    // immediate in non-PWM, loaded at TOP tick in PWM
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cmp_r <= TMR_RESET_BYTE;
        else if (!pwm && wr_cmp)
            cmp_r <= bus.wdata;
        else if (!pwm)
            cmp_r <= cmp_buf_r;
        else if (tick && at_top)
            cmp_r <= cmp_buf_r;
    end

    // block next tick's match after counter write
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            block_r <= 1'b0;
        else if (wr_count)
            block_r <= 1'b1;
        else if (tick)
            block_r <= 1'b0;
    end

    // ==========================================
    // counter
    // software write has priority over counting
    // fast PWM wraps MAX to zero; force never clears counter
    always_comb
    begin
        count_nxt = count_r;
        if (wr_count)
            count_nxt = bus.wdata;
        else if (tick)
        begin
            if (mode == TMR_PWM_PC)
                count_nxt = down_r ? count_r - 8'h01 : count_r + 8'h01;
            else if (at_top)
                count_nxt = TMR_BOTTOM;
            else
                count_nxt = count_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            count_r <= TMR_BOTTOM;
        else
            count_r <= count_nxt;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            down_r <= 1'b0;
        else if (mode != TMR_PWM_PC)
            down_r <= 1'b0;
        else if (tick && count_r == TMR_MAX - 8'h01 && !down_r)
            down_r <= 1'b1;
        else if (tick && count_r == TMR_BOTTOM + 8'h01 && down_r)
            down_r <= 1'b0;
    end

    // ==========================================
    // waveform output

    // non-PWM action of the output field, shared by match and force
    function automatic logic com_action(input tmr_com_t c, input logic cur);
        logic nxt;
        nxt = cur;
        unique case (c)
            TMR_COM_OFF: nxt = cur;
            TMR_COM_TOGGLE: nxt = !cur;
            TMR_COM_CLEAR: nxt = 1'b0;
            TMR_COM_SET: nxt = 1'b1;
        endcase
        return nxt;
    endfunction

    assign fast_top_hit = (mode == TMR_PWM_FAST) && com[1] && tick && at_top;

    // compare at MAX: match ignored, level set as if down-match
    assign pc_top_hit = (mode == TMR_PWM_PC) && com[1] && tick
                        && (count_r == TMR_MAX) && (cmp_r == TMR_MAX);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            oc_r <= 1'b0;
        else if (force_compare_strobe)
            oc_r <= com_action(tmr_com_t'(force_com), oc_r);
        else if (!pwm && match)
            oc_r <= com_action(com, oc_r);
        else if (fast_top_hit)
            oc_r <= !com[0];
        else if (mode == TMR_PWM_FAST && com[1] && match)
            oc_r <= com[0];
        else if (mode == TMR_PWM_PC && com[1] && match)
            oc_r <= down_r ? !com[0] : com[0];
        else if (pc_top_hit)
            oc_r <= !com[0];
    end

    // override when field nonzero, except toggle value in PWM modes; direction bit kept outside
    assign compare_output_override = (com == TMR_COM_TOGGLE) ? !pwm : (com != TMR_COM_OFF);
    assign compare_output_pin = oc_r;

    // ==========================================
    // flags and interrupts

    // match sets flag; force does not
    assign cmp_set = match;

    // phase-correct at bottom; wrap from MAX elsewhere
    assign ovf_set = tick && ((mode == TMR_PWM_PC) ? (down_r && count_r == TMR_BOTTOM + 8'h01)
                                                  : (mode == TMR_CTC ? count_r == TMR_MAX : at_top));

    assign wr_flags = hit(bus.addr, TMR_OFF_FLAGS, bus.wr);
    assign wr_mask = hit(bus.addr, TMR_OFF_MASK, bus.wr);

    assign clr_cmp = compare_irq_ack || (wr_flags && bus.wdata[TMR_BIT_CMP]);

    assign clr_ovf = overflow_irq_ack || (wr_flags && bus.wdata[TMR_BIT_OVF]);

    // set wins over clear so that no event is lost to a late acknowledge
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cmp_flag_r <= 1'b0;
        else if (cmp_set)
            cmp_flag_r <= 1'b1;
        else if (clr_cmp)
            cmp_flag_r <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ovf_flag_r <= 1'b0;
        else if (ovf_set)
            ovf_flag_r <= 1'b1;
        else if (clr_ovf)
            ovf_flag_r <= 1'b0;
    end

    // reserved mask bits are not stored, so they read zero
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            mask_r <= 2'b00;
        else if (wr_mask)
            mask_r <= bus.wdata[1:0];
    end

    assign compare_irq = mask_r[TMR_BIT_CMP] && global_irq_enable && cmp_flag_r;

    assign overflow_irq = mask_r[TMR_BIT_OVF] && global_irq_enable && ovf_flag_r;

    // ==========================================
    // read port

    // force bit reads zero via control mask
    always_comb
    begin
        rdata_nxt = TMR_RESET_BYTE;
        if (bus.rd)
        begin
            unique case (bus.addr)
                TMR_OFF_CONTROL_A: rdata_nxt = ctrl_r & TMR_CTRL_MASK;
                TMR_OFF_COUNT: rdata_nxt = count_r;
                TMR_OFF_COMPARE: rdata_nxt = cmp_buf_r;
                TMR_OFF_MASK: rdata_nxt = {6'h00, mask_r};
                TMR_OFF_FLAGS: rdata_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
                default: rdata_nxt = TMR_RESET_BYTE;
            endcase
        end
    end

    // data stands one cycle only; idle zero keeps stale values off the bus
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= TMR_RESET_BYTE;
        else
            rdata <= rdata_nxt;
    end

endmodule // tmr_timer8
`default_nettype wire

//--- verification/tmr_timer8_asserts.sv
`default_nettype none
module tmr_timer8_asserts
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire tmr_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    input wire logic compare_irq,
    input wire logic overflow_irq,
    input wire logic external_count_pin,
    input wire logic compare_output_pin,
    input wire logic compare_output_override
);
    // ========================================
    // shadow of software-written fields
    logic [7:0] ctl_r;
    logic [1:0] msk_r;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_r <= 8'h00;
            msk_r <= 2'h0;
        end
        else if (bus.wr && bus.addr == TMR_OFF_CONTROL_A)
            ctl_r <= bus.wdata;
        else if (bus.wr && bus.addr == TMR_OFF_MASK)
            msk_r <= bus.wdata[1:0];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ========================================
    // properties
    AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not idle");
    AST_CTRL_RB: assert property (bus.rd && bus.addr == TMR_OFF_CONTROL_A |=> rdata == (ctl_r & TMR_CTRL_MASK))
        else $error("control readback wrong");
    AST_MASK_RB: assert property (bus.rd && bus.addr == TMR_OFF_MASK |=> rdata == {6'h00, msk_r})
        else $error("mask readback wrong");
    AST_FLAG_RSV: assert property (bus.rd && bus.addr == TMR_OFF_FLAGS |=> rdata[7:2] == 6'h00)
        else $error("flag spare bits set");
    AST_UNMAP: assert property (bus.rd && bus.addr > TMR_OFF_FLAGS |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CIRQ: assert property (compare_irq |-> global_irq_enable && msk_r[TMR_BIT_CMP])
        else $error("compare request unqualified");
    AST_OIRQ: assert property (overflow_irq |-> global_irq_enable && msk_r[TMR_BIT_OVF])
        else $error("overflow request unqualified");
    AST_OVR: assert property (compare_output_override == (ctl_r[5:4] != 2'h0 && !(ctl_r[3] && ctl_r[5:4] == 2'h1)))
        else $error("override wrong");
    AST_PIN_STOP: assert property (ctl_r[2:0] == 3'h0 && !bus.wr && !$past(bus.wr) |=> $stable(compare_output_pin))
        else $error("pin moved while stopped");
    cover property (compare_irq);
    cover property (overflow_irq);
    cover property (compare_output_override && $changed(compare_output_pin));
endmodule // tmr_timer8_asserts
`default_nettype wire

//--- verification/tmr_timer8_tb.sv
`default_nettype none
module tmr_timer8_tb
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, resetn, global_irq_enable, compare_irq_ack, overflow_irq_ack, external_count_pin;
    logic compare_irq, overflow_irq, compare_output_pin, compare_output_override;
    tmr_bus_t bus;
    logic [7:0] rdata, got;
    int bad_count, samples_checked;
    tmr_timer8 u_tmr_timer8 (.sys_clk, .resetn, .bus, .rdata, .global_irq_enable, .compare_irq_ack,
        .overflow_irq_ack, .compare_irq, .overflow_irq, .external_count_pin, .compare_output_pin,
        .compare_output_override);
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ========================================
    // shared tasks
    task automatic final_report();
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        // let the write settle before a caller looks at outputs
        #1;
    endtask
    task automatic rd(logic [2:0] a);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic rdc(string n, logic [2:0] a, logic [7:0] e);
        rd(a);
        chk(n, e, got);
    endtask
    // polling bound covers a full count cycle at two cycles a read
    task automatic wait_flag(int b);
        for (int i = 0; i < 300; i++)
        begin
            rd(TMR_OFF_FLAGS);
            if (got[b] === 1'b1)
                return;
        end
        bad_count++;
        final_report();
    endtask
    task automatic force_pin(logic [7:0] c, logic e);
        wr(TMR_OFF_CONTROL_A, c);
        cyc(2);
        chk("pin", {7'h00, e}, {7'h00, compare_output_pin});
    endtask
    task automatic ext_pulses(int n);
        repeat (n)
        begin
            @(posedge sys_clk) external_count_pin <= 1'b1;
            cyc(3);
            @(posedge sys_clk) external_count_pin <= 1'b0;
            cyc(3);
        end
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        rdc("mask", TMR_OFF_MASK, 8'h00);
        wr(3'h5, 8'hff);
        rdc("unmapped", 3'h5, 8'h00);
        wr(TMR_OFF_COUNT, 8'h5a);
        rdc("count", TMR_OFF_COUNT, 8'h5a);
        wr(TMR_OFF_CONTROL_A, 8'hff);
        rdc("control", TMR_OFF_CONTROL_A, 8'h7f);
        wr(TMR_OFF_CONTROL_A, 8'h00);
        wr(TMR_OFF_MASK, 8'hff);
        rdc("mask", TMR_OFF_MASK, 8'h03);
    endtask
    task automatic t_flags();
        wr(TMR_OFF_COMPARE, 8'h80);
        wr(TMR_OFF_FLAGS, 8'h03);
        wr(TMR_OFF_COUNT, 8'hf8);
        wr(TMR_OFF_CONTROL_A, 8'h01);
        wait_flag(TMR_BIT_OVF);
        chk("flags", 8'h01, got);
        @(posedge sys_clk) global_irq_enable <= 1'b1;
        cyc(1);
        chk("ovf_irq", 8'h01, {7'h00, overflow_irq});
        wr(TMR_OFF_FLAGS, 8'h01);
        rdc("flags", TMR_OFF_FLAGS, 8'h00);
        wait_flag(TMR_BIT_CMP);
        wr(TMR_OFF_MASK, 8'h01);
        chk("cmp_irq", 8'h00, {7'h00, compare_irq});
        wr(TMR_OFF_MASK, 8'h03);
        chk("cmp_irq", 8'h01, {7'h00, compare_irq});
        @(posedge sys_clk) compare_irq_ack <= 1'b1;
        @(posedge sys_clk) compare_irq_ack <= 1'b0;
        rdc("flags", TMR_OFF_FLAGS, 8'h00);
        wait_flag(TMR_BIT_OVF);
        @(posedge sys_clk) overflow_irq_ack <= 1'b1;
        @(posedge sys_clk) overflow_irq_ack <= 1'b0;
        rdc("flags", TMR_OFF_FLAGS, 8'h00);
        wr(TMR_OFF_CONTROL_A, 8'h00);
    endtask
    task automatic t_block();
        wr(TMR_OFF_COUNT, 8'h20);
        wr(TMR_OFF_COMPARE, 8'h40);
        wr(TMR_OFF_CONTROL_A, 8'h01);
        wr(TMR_OFF_COUNT, 8'h40);
        cyc(3);
        wr(TMR_OFF_CONTROL_A, 8'h00);
        rdc("flags", TMR_OFF_FLAGS, 8'h00);
    endtask
    task automatic t_force();
        wr(TMR_OFF_FLAGS, 8'h03);
        wr(TMR_OFF_CONTROL_A, 8'h30);
        force_pin(8'hb0, 1'b1);
        force_pin(8'ha0, 1'b0);
        force_pin(8'h90, 1'b1);
        force_pin(8'h90, 1'b0);
        chk("override", 8'h01, {7'h00, compare_output_override});
        rdc("flags", TMR_OFF_FLAGS, 8'h00);
        force_pin(8'hb0, 1'b1);
        wr(TMR_OFF_CONTROL_A, 8'h68);
        force_pin(8'he8, 1'b1);
        wr(TMR_OFF_CONTROL_A, 8'h58);
        chk("override", 8'h00, {7'h00, compare_output_override});
    endtask
    task automatic t_clock();
        wr(TMR_OFF_COUNT, 8'h10);
        wr(TMR_OFF_CONTROL_A, 8'h07);
        ext_pulses(3);
        rdc("count", TMR_OFF_COUNT, 8'h13);
        wr(TMR_OFF_CONTROL_A, 8'h06);
        ext_pulses(3);
        rdc("count", TMR_OFF_COUNT, 8'h16);
        wr(TMR_OFF_CONTROL_A, 8'h02);
        wr(TMR_OFF_COUNT, 8'h00);
        cyc(80);
        wr(TMR_OFF_CONTROL_A, 8'h00);
        rd(TMR_OFF_COUNT);
        // prescaler phase is free running, so allow one tick either way
        chk("div8", 8'h01, {7'h00, got >= 8'h09 && got <= 8'h0b});
    endtask
    initial
    begin
        bad_count = 0;
        samples_checked = 0;
        bus = '0;
        resetn = 1'b0;
        global_irq_enable = 1'b0;
        compare_irq_ack = 1'b0;
        overflow_irq_ack = 1'b0;
        external_count_pin = 1'b0;
        cyc(5);
        resetn <= 1'b1;
        t_regs();
        t_flags();
        t_block();
        t_force();
        t_clock();
        final_report();
    end
endmodule // tmr_timer8_tb
bind tmr_timer8 tmr_timer8_asserts u_tmr_timer8_asserts (.sys_clk, .resetn, .bus, .rdata, .global_irq_enable,
    .compare_irq_ack, .overflow_irq_ack, .compare_irq, .overflow_irq, .external_count_pin, .compare_output_pin,
    .compare_output_override);
`default_nettype wire
